/* shared/mirq_pkg.sv */
// mirq_pkg: constants and carrier types of the interrupt and reset-state block
// assumes one 20 MHz clock with four clock phases per instruction cycle
`default_nettype none
package mirq_pkg;
    // -------------------------------------------------------------
    // register addresses
    // -------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h03; // core status
    localparam logic [7:0] ADDR_INTCTL = 8'h0B; // interrupt_control
    localparam logic [7:0] ADDR_PIFLG  = 8'h0C; // peripheral_int_flags
    localparam logic [7:0] ADDR_OPTION = 8'h81; // option, edge select
    localparam logic [7:0] ADDR_PIEN   = 8'h8C; // peripheral_int_enables
    localparam logic [7:0] ADDR_PWR    = 8'h8E; // power_status
    localparam logic [7:0] ADDR_ANALOG_PIN_SELECT  = 8'h91; // analog_pin_select
    localparam logic [7:0] ADDR_CHGSEL = 8'h96; // change_pin_select
    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int GIE_BIT  = 7; // global_int_enable
    localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6; // peripheral_group_enable
    localparam int EDGE_BIT = 6; // ext_edge_select in option
    localparam int TO_BIT   = 4; // timeout flag, active low
    localparam int PD_BIT   = 3; // power-down flag, active low
    localparam int BOR_BIT  = 0; // brown-out flag, active low
    localparam int EXT_PIN  = 2; // external_int_pin in port
    localparam int NUM_SRC  = 11;
    // -------------------------------------------------------------
    // reset values and vectors
    // -------------------------------------------------------------
    localparam logic [7:0]  RST_INTCTL = 8'h00;
    localparam logic [7:0]  RST_PIFLG  = 8'h00;
    localparam logic [7:0]  RST_PIEN   = 8'h00;
    localparam logic [7:0]  RST_OPTION = 8'hFF;
    localparam logic [7:0]  RST_ANALOG_PIN_SELECT  = 8'hFF;
    localparam logic [5:0]  RST_CHGSEL = 6'h00;
    localparam logic [7:0]  RST_STATUS = 8'h18;
    localparam logic [1:0]  RST_PWR    = 2'h1;
    localparam logic [12:0] VEC_RESET  = 13'h0000;
    localparam logic [12:0] VEC_INT    = 13'h0004;
    localparam logic [7:0]  T0_MAX     = 8'hFF;
    // -------------------------------------------------------------
    // timing: clock phases and take delay in instruction cycles
    // -------------------------------------------------------------
    localparam logic [1:0] Q1_PHASE = 2'h0;
    localparam logic [1:0] Q4_PHASE = 2'h3;
    localparam logic [1:0] TAKE_DLY = 2'h2;
    // -------------------------------------------------------------
    // carrier types
    // -------------------------------------------------------------
    typedef struct packed {
        logic       wr;    // write strobe
        logic       rd;    // read strobe
        logic [7:0] addr;  // register address
        logic [7:0] wdata; // write data
    } mirq_bus_t;
    typedef struct packed {
        logic master_clear;     // master_clear reset
        logic wdt_rst;  // watchdog reset while awake
        logic wdt_wake; // watchdog wake-up from sleep
        logic bor;      // brown-out reset
    } mirq_rst_t;
    typedef struct packed {
        logic        valid; // load the program counter
        logic        push;  // push return address first
        logic        inc;   // advance to the next instruction
        logic [12:0] addr;  // target when inc is low
    } mirq_pc_t;
endpackage : mirq_pkg
`default_nettype wire

/* logic/mirq_ctrl.sv */
// mirq_ctrl: interrupt control, sleep wake-up and reset-state logic
// assumes all inputs synchronous to sys_clk and event inputs one cycle long
//
// Functional notes
// - eleven interrupt sources are accepted
// - global enable gates every unmasked interrupt
// - each source has its own enable
// - every reset clears global enable
// - taking: clear enable, push, vector 0004h
// - return from service sets global enable
// - flags set regardless of any enable
// - cleared global enable drops due requests; pending
// - latency three cycles, four for late events
// - pin edge chosen by edge select bit
// - pin edge sets flag; enable gates it
// - pin flag set Q4-Q1, sampled each Q1
// - pin wakes sleep only if enabled before
// - analog pins read zero, never interrupt
// - timer rollover FFh to 00h sets flag
// - selected port pin change sets change flag
// - change during port access may be lost
// - peripheral flags and enables share positions
// - hardware saves only the return address
// - interrupt wake: next instruction, status uuu1 0uuu
// - enabled wake runs next instruction, then vectors
// - master clear awake: 000h, status 000u uuuu
// - master clear asleep: 000h, status 0001 0uuu
// - brown-out alone clears power status bit 0
`timescale 1ns/1ps
`default_nettype none
module mirq_ctrl (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire mirq_pkg::mirq_bus_t bus_req,
    output logic [7:0]             rd_data,
    input  wire mirq_pkg::mirq_rst_t rst_kind,
    input  wire logic              ret_from_isr,
    input  wire logic              sleep_enter,
    input  wire logic              port_access,
    input  wire logic [5:0]        monitored_port,
    input  wire logic [7:0]        timer0_count,
    input  wire logic [7:0]        periph_events,
    output logic                   irq_pending,
    output logic                   irq_take,
    output mirq_pkg::mirq_pc_t     pc_cmd,
    output logic [1:0]             q_phase,
    output logic                   asleep,
    output logic [5:0]             port_digital
);
    import mirq_pkg::*;

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    logic [1:0]  q_cnt_q;      // clock phase counter
    logic [7:0]  intctl_q;     // interrupt_control
    logic [7:0]  piflg_q;      // peripheral_int_flags
    logic [7:0]  pien_q;       // peripheral_int_enables
    logic [7:0]  option_q;     // option, edge select inside
    logic [7:0]  analog_pin_select_q;      // analog_pin_select
    logic [5:0]  chgsel_q;     // change_pin_select
    logic [7:0]  status_q;     // core status image
    logic [1:0]  pwr_q;        // power_status
    logic [1:0]  take_cnt_q;   // instruction cycles since sample
    logic        asleep_q;     // core is in sleep
    logic        ext_pin_int_enable_slp_q;   // pin enable captured at sleep
    logic        ext_prev_q;   // pin level last cycle
    logic        ext_pend_q;   // edge waiting for Q4/Q1
    logic [5:0]  port_ref_q;   // last seen digital port
    logic [7:0]  t0_prev_q;    // timer value last cycle
    logic [7:0]  rd_data_q;    // read data register
    logic        take_q;       // registered take pulse
    mirq_pc_t    pc_cmd_q;     // registered pc command
    logic [5:0]  port_dig_q;   // registered digital port

    // -------------------------------------------------------------
    // decode helpers
    // -------------------------------------------------------------
    // write strobe aimed at one address
    function automatic logic wr_hit(input mirq_bus_t b,
                                    input logic [7:0] a);
        return b.wr && (b.addr == a);
    endfunction : wr_hit

    // -------------------------------------------------------------
    // clock phases
    // -------------------------------------------------------------
    wire q1_en = (q_cnt_q == Q1_PHASE); // first phase strobe
    wire q4_en = (q_cnt_q == Q4_PHASE); // last phase strobe

    // phase divider, one instruction cycle every four clocks
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q_cnt_q <= Q1_PHASE;
        end else begin
            q_cnt_q <= q_cnt_q + 2'h1;
        end
    end

    // -------------------------------------------------------------
    // bus decode and reset kinds
    // -------------------------------------------------------------
    wire wr_intctl = wr_hit(bus_req, ADDR_INTCTL);
    wire wr_piflg  = wr_hit(bus_req, ADDR_PIFLG);
    wire wr_pien   = wr_hit(bus_req, ADDR_PIEN);
    wire wr_option = wr_hit(bus_req, ADDR_OPTION);
    wire wr_analog_pin_select  = wr_hit(bus_req, ADDR_ANALOG_PIN_SELECT);
    wire wr_chgsel = wr_hit(bus_req, ADDR_CHGSEL);
    wire wr_status = wr_hit(bus_req, ADDR_STATUS);
    wire wr_pwr    = wr_hit(bus_req, ADDR_PWR);
    // any reset that restarts the core at 000h
    wire dev_rst   = rst_kind.master_clear | rst_kind.wdt_rst | rst_kind.bor;

    // -------------------------------------------------------------
    // pin conditioning
    // -------------------------------------------------------------
    // analog pins read as zero so they never make an edge
    wire [5:0] port_dig_w = monitored_port & ~analog_pin_select_q[5:0];

    // external pin edge detection
    wire ext_lvl   = port_dig_w[EXT_PIN];
    wire ext_rise  = ext_lvl & ~ext_prev_q;
    wire ext_fall  = ~ext_lvl & ext_prev_q;
    wire ext_edge  = option_q[EDGE_BIT] ? ext_rise : ext_fall;
    // flag may only be set in the Q4-Q1 window
    wire ext_win   = q4_en | q1_en;
    wire ext_set   = (ext_pend_q | ext_edge) & ext_win;

    // port change detection, one comparator per pin
    logic [5:0] chg_w; // selected pins that changed
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_chg
            assign chg_w[gi] = chgsel_q[gi]
                             & (port_dig_w[gi] ^ port_ref_q[gi]);
        end
    endgenerate
    // a change that meets a port access is dropped
    wire chg_set = (|chg_w) & ~port_access;

    // timer rollover, FFh followed by 00h
    wire t0_ovf = (t0_prev_q == T0_MAX) && (timer0_count == 8'h00);

    // -------------------------------------------------------------
    // request and wake logic
    // -------------------------------------------------------------
    // core enables bits 5:3 line up with core flags bits 2:0
    wire [2:0] core_pair = intctl_q[5:3] & intctl_q[2:0];
    wire [7:0] per_pair  = piflg_q & pien_q;
    wire core_any = |core_pair;
    wire per_any  = intctl_q[PERIPHERAL_GROUP_ENABLE_BIT] & (|per_pair);
    wire global_int_enable      = intctl_q[GIE_BIT];
    // eleven sources: three core, eight peripheral
    wire src_any  = core_any | per_any;
    wire irq_req  = global_int_enable & src_any;

    // pin wakes only with its enable captured at sleep entry
    wire [2:0] wake_msk = {1'b1, ext_pin_int_enable_slp_q, 1'b1};
    wire wake_src = (|(core_pair & wake_msk)) | (|per_pair);
    // wake does not look at global enable
    wire int_wake = asleep_q & wake_src;
    wire wdt_wake = asleep_q & rst_kind.wdt_wake;

    // take fires on Q1 two cycles after the sampling Q1
    wire take_w = q1_en & (take_cnt_q == TAKE_DLY)
                & irq_req & ~asleep_q & ~dev_rst;

    // -------------------------------------------------------------
    // next values of software-visible registers
    // -------------------------------------------------------------
    wire [2:0] core_set = {t0_ovf, ext_set, chg_set};
    wire [7:0] ictl_base = wr_intctl ? bus_req.wdata : intctl_q;
    // take clears, return sets, else software value
    wire gie_d = take_w       ? 1'b0 :
                 ret_from_isr ? 1'b1 :
                 ictl_base[GIE_BIT];
    // set wins over a software clear in the same cycle
    wire [7:0] intctl_d = {gie_d, ictl_base[6:3],
                           ictl_base[2:0] | core_set};
    wire [7:0] piflg_d  = (wr_piflg ? bus_req.wdata : piflg_q)
                        | periph_events;

    // status: software owns all bits but the two low-active flags
    wire [7:0] st_sw = wr_status
                     ? {bus_req.wdata[7:5], status_q[4:3],
                        bus_req.wdata[2:0]}
                     : status_q;
    // status pattern per event kind
    wire [7:0] st_master_clear = asleep_q
                       ? {4'h1, 1'b0, status_q[2:0]}
                       : {3'h0, status_q[4:0]};
    wire [7:0] st_wdtr = {4'h0, status_q[3:0]};
    wire [7:0] st_bor  = {3'h0, 2'h3, status_q[2:0]};
    wire [7:0] st_iwk  = {status_q[7:5], 2'h2, status_q[2:0]};
    wire [7:0] st_wwk  = {status_q[7:5], 2'h0, status_q[2:0]};
    wire [7:0] st_slp  = {status_q[7:5], 2'h2, status_q[2:0]};
    wire [7:0] status_d = rst_kind.bor     ? st_bor  :
                          rst_kind.master_clear    ? st_master_clear :
                          rst_kind.wdt_rst ? st_wdtr :
                          wdt_wake         ? st_wwk  :
                          int_wake         ? st_iwk  :
                          sleep_enter      ? st_slp  :
                          st_sw;
    // brown-out clears bit 0, the rest keep it
    wire [1:0] pwr_sw = wr_pwr ? bus_req.wdata[1:0] : pwr_q;
    wire [1:0] pwr_d  = rst_kind.bor
                      ? {pwr_sw[1], 1'b0}
                      : pwr_sw;

    // -------------------------------------------------------------
    // program counter command
    // -------------------------------------------------------------
    // only the return address is saved by hardware
    wire mirq_pc_t pc_take = '{valid: 1'b1, push: 1'b1,
                               inc: 1'b0, addr: VEC_INT};
    wire mirq_pc_t pc_rst  = '{valid: 1'b1, push: 1'b0,
                               inc: 1'b0, addr: VEC_RESET};
    wire mirq_pc_t pc_wake = '{valid: 1'b1, push: 1'b0,
                               inc: 1'b1, addr: VEC_RESET};
    wire mirq_pc_t pc_none = '{valid: 1'b0, push: 1'b0,
                               inc: 1'b0, addr: VEC_RESET};
    wire mirq_pc_t pc_d = dev_rst               ? pc_rst  :
                          (int_wake | wdt_wake) ? pc_wake :
                          take_w                ? pc_take :
                          pc_none;

    // -------------------------------------------------------------
    // read mux, unmapped addresses read zero
    // -------------------------------------------------------------
    wire [7:0] rd_val =
        (bus_req.addr == ADDR_INTCTL) ? intctl_q :
        (bus_req.addr == ADDR_PIFLG)  ? piflg_q  :
        (bus_req.addr == ADDR_PIEN)   ? pien_q   :
        (bus_req.addr == ADDR_OPTION) ? option_q :
        (bus_req.addr == ADDR_ANALOG_PIN_SELECT)  ? analog_pin_select_q  :
        (bus_req.addr == ADDR_CHGSEL) ? {2'h0, chgsel_q} :
        (bus_req.addr == ADDR_STATUS) ? status_q :
        (bus_req.addr == ADDR_PWR)    ? {6'h00, pwr_q} :
        8'h00;

    // -------------------------------------------------------------
    // interrupt registers
    // -------------------------------------------------------------
    // flags, enables and global enable
    always_ff @(posedge sys_clk) begin
        if (srst || dev_rst) begin
            intctl_q <= RST_INTCTL;
            piflg_q  <= RST_PIFLG;
            pien_q   <= RST_PIEN;
        end else begin
            intctl_q <= intctl_d;
            piflg_q  <= piflg_d;
            pien_q   <= wr_pien ? bus_req.wdata : pien_q;
        end
    end

    // configuration registers
    always_ff @(posedge sys_clk) begin
        if (srst || dev_rst) begin
            option_q <= RST_OPTION;
            analog_pin_select_q  <= RST_ANALOG_PIN_SELECT;
            chgsel_q <= RST_CHGSEL;
        end else begin
            option_q <= wr_option ? bus_req.wdata : option_q;
            analog_pin_select_q  <= wr_analog_pin_select ? bus_req.wdata : analog_pin_select_q;
            chgsel_q <= wr_chgsel ? bus_req.wdata[5:0] : chgsel_q;
        end
    end

    // status and power status images
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            status_q <= RST_STATUS;
            pwr_q    <= RST_PWR;
        end else begin
            status_q <= status_d;
            pwr_q    <= pwr_d;
        end
    end

    // -------------------------------------------------------------
    // event edge history
    // -------------------------------------------------------------
    // pin, port and timer history; pending pin edge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ext_prev_q <= 1'b0;
            ext_pend_q <= 1'b0;
            port_ref_q <= 6'h00;
            t0_prev_q  <= 8'h00;
        end else begin
            ext_prev_q <= ext_lvl;
            // hold an edge until the Q4-Q1 window
            ext_pend_q <= (ext_pend_q | ext_edge) & ~ext_win;
            port_ref_q <= port_dig_w;
            t0_prev_q  <= timer0_count;
        end
    end

    // -------------------------------------------------------------
    // recognition and sleep
    // -------------------------------------------------------------
    // take counter: start on a sampling Q1, abort if request drops
    always_ff @(posedge sys_clk) begin
        if (srst || dev_rst || !irq_req) begin
            take_cnt_q <= 2'h0;
        end else if (q1_en) begin
            if (take_cnt_q == 2'h0) begin
                // sample on Q1 only while awake
                take_cnt_q <= asleep_q ? 2'h0 : 2'h1;
            end else if (take_cnt_q == TAKE_DLY) begin
                take_cnt_q <= 2'h0; // taken now
            end else begin
                take_cnt_q <= take_cnt_q + 2'h1;
            end
        end
    end

    // sleep state, wake by enabled source or watchdog
    always_ff @(posedge sys_clk) begin
        if (srst || dev_rst) begin
            asleep_q   <= 1'b0;
            ext_pin_int_enable_slp_q <= 1'b0;
        end else if (int_wake || wdt_wake) begin
            // global enable set: take follows next instruction
            asleep_q   <= 1'b0;
            ext_pin_int_enable_slp_q <= ext_pin_int_enable_slp_q;
        end else if (sleep_enter) begin
            asleep_q   <= 1'b1;
            ext_pin_int_enable_slp_q <= intctl_q[4];
        end
    end

    // -------------------------------------------------------------
    // outputs, registered except irq_pending
    // -------------------------------------------------------------
    // read data, take pulse, pc command and port image
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_data_q  <= 8'h00;
            take_q     <= 1'b0;
            pc_cmd_q   <= pc_rst;
            port_dig_q <= 6'h00;
        end else begin
            rd_data_q  <= bus_req.rd ? rd_val : 8'h00;
            take_q     <= take_w;
            pc_cmd_q   <= pc_d;
            port_dig_q <= port_dig_w;
        end
    end

    assign rd_data      = rd_data_q;
    assign irq_take     = take_q;
    assign pc_cmd       = pc_cmd_q;
    assign irq_pending  = irq_req;
    assign q_phase      = q_cnt_q;
    assign asleep       = asleep_q;
    assign port_digital = port_dig_q;
endmodule : mirq_ctrl
`default_nettype wire

/* test/mirq_ctrl_asserts.sv */
// mirq_ctrl_asserts: port-level timing checks of mirq_ctrl
// assumes one clock sys_clk and a synchronous active-high srst
`timescale 1ns/1ps
`default_nettype none
module mirq_ctrl_asserts (
    input wire logic                sys_clk,
    input wire logic                srst,
    input wire mirq_pkg::mirq_rst_t rst_kind,
    input wire logic                irq_pending,
    input wire logic                irq_take,
    input wire mirq_pkg::mirq_pc_t  pc_cmd,
    input wire logic [1:0]          q_phase,
    input wire logic                asleep
);
    import mirq_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // awake request seen on a first phase, then held awake
    sequence s_sample; irq_pending && !asleep && q_phase == Q1_PHASE; endsequence
    sequence s_hold; irq_pending && !asleep && rst_kind == '0; endsequence
    property p_take_vec; irq_take |-> pc_cmd.valid && pc_cmd.push && pc_cmd.addr == VEC_INT; endproperty
    a_take_vec: assert property (p_take_vec) else $error("take without push and vector");
    property p_take_gie; irq_take |-> !irq_pending; endproperty
    a_take_gie: assert property (p_take_gie) else $error("global enable kept at take");
    property p_take_cause; $rose(irq_take) |-> $past(irq_pending) && $past(q_phase) == Q1_PHASE; endproperty
    a_take_cause: assert property (p_take_cause) else $error("take not on a sampled first phase");
    property p_phase; !srst |=> q_phase == $past(q_phase) + 2'h1; endproperty
    a_phase: assert property (p_phase) else $error("phase counter skipped");
    property p_latency; s_sample ##1 s_hold [*8] |=> irq_take; endproperty
    a_latency: assert property (p_latency) else $error("take late");
    property p_drop; !irq_pending |=> !irq_take [*8]; endproperty
    a_drop: assert property (p_drop) else $error("take after request dropped");
    property p_rst_pc;
        (rst_kind.master_clear || rst_kind.bor || rst_kind.wdt_rst)
            |-> ##[1:2] (pc_cmd.valid && !pc_cmd.inc && pc_cmd.addr == VEC_RESET);
    endproperty
    a_rst_pc: assert property (p_rst_pc) else $error("no reset vector");
    property p_rst_gie; (rst_kind.master_clear || rst_kind.bor || rst_kind.wdt_rst) |=> !irq_pending; endproperty
    a_rst_gie: assert property (p_rst_gie) else $error("request survives reset");
    property p_wake;
        $fell(asleep) && !$past(srst) && $past(rst_kind) == '0 |-> ##[0:1] (pc_cmd.valid && pc_cmd.inc);
    endproperty
    a_wake: assert property (p_wake) else $error("wake without advance");
endmodule : mirq_ctrl_asserts
`default_nettype wire

/* test/mirq_core_model.sv */
// mirq_core_model: core that runs a service routine and returns
// assumes irq_take is a one-cycle pulse on sys_clk
`timescale 1ns/1ps
`default_nettype none
module mirq_core_model (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       irq_take,
    input  wire logic [3:0] svc_len,
    output logic            ret_from_isr
);
    logic [4:0] cnt_q; // cycles left in the routine
    // count the routine down, return on its last cycle
    always_ff @(posedge sys_clk) begin
        if (srst || irq_take) begin
            cnt_q <= srst ? 5'h00 : {1'b0, svc_len} + 5'h01;
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
        end
        ret_from_isr <= !srst && cnt_q == 5'h01;
    end
endmodule : mirq_core_model
`default_nettype wire

/* test/mirq_ctrl_tb.sv */
// mirq_ctrl_tb: self-checking bench of mirq_ctrl with a core model
// assumes package, design, checker and model compiled first
`timescale 1ns/1ps
`default_nettype none
module mirq_ctrl_tb;
    import mirq_pkg::*;
    logic       sys_clk, srst, ret_from_isr, sleep_enter, port_access, irq_pending, irq_take, asleep, seen;
    logic [1:0] q_phase;
    logic [3:0] svc_len;
    logic [5:0] monitored_port, port_digital;
    logic [7:0] rd_data, timer0_count, periph_events, got, rnd;
    logic [7:0] ra [5] = '{ADDR_INTCTL, ADDR_PIFLG, ADDR_PIEN, ADDR_CHGSEL, 8'h55};
    mirq_bus_t  bus_req;
    mirq_rst_t  rst_kind;
    mirq_pc_t   pc_cmd;
    int         miscompares, num_checks;
    mirq_ctrl u_dut (.sys_clk(sys_clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
        .rst_kind(rst_kind), .ret_from_isr(ret_from_isr), .sleep_enter(sleep_enter),
        .port_access(port_access), .monitored_port(monitored_port), .timer0_count(timer0_count),
        .periph_events(periph_events), .irq_pending(irq_pending), .irq_take(irq_take),
        .pc_cmd(pc_cmd), .q_phase(q_phase), .asleep(asleep), .port_digital(port_digital));
    mirq_core_model u_core (.sys_clk(sys_clk), .srst(srst), .irq_take(irq_take), .svc_len(svc_len),
        .ret_from_isr(ret_from_isr));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic cyc(input int n); repeat (n) @(posedge sys_clk); endtask : cyc
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen_v);
        num_checks++;
        if (seen_v !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen_v);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        cyc(1);
        bus_req <= '0;
        cyc(1);
    endtask : wr
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        cyc(1);
        bus_req <= '0;
        #1 chk(what, exp, rd_data);
        cyc(1);
    endtask : rchk
    // bounded wait for a take (0) or a wake advance (1)
    task automatic wait_for(input bit wake, output logic s);
        s = 1'b0;
        for (int i = 0; i < 40 && s !== 1'b1; i++) begin
            cyc(1);
            #1 s = wake ? (pc_cmd.valid && pc_cmd.inc) : irq_take;
        end
        cyc(1);
    endtask : wait_for
    task automatic pulse(input int k);
        if (k == 0) timer0_count <= T0_MAX; else if (k == 1) sleep_enter <= 1'b1;
        else if (k == 2) rst_kind.bor <= 1'b1; else rst_kind.master_clear <= 1'b1;
        cyc(1);
        timer0_count <= 8'h00;
        sleep_enter <= 1'b0;
        rst_kind <= '0;
        cyc(3);
    endtask : pulse
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        cyc(5000);
        miscompares++;
        wrap_up();
    end
    initial begin
        miscompares = 0; num_checks = 0; rnd = 8'($urandom(75)); srst = 1'b1; bus_req = '0; rst_kind = '0;
        sleep_enter = 1'b0; port_access = 1'b0; monitored_port = 6'h00; timer0_count = 8'h10;
        periph_events = 8'h00; svc_len = 4'h8 + 4'($urandom % 8);
        cyc(3);
        srst <= 1'b0;
        cyc(1);
        foreach (ra[i]) rchk("reset value", ra[i], 8'h00);
        rchk("status", ADDR_STATUS, RST_STATUS);
        rnd = 8'($urandom);
        wr(ADDR_CHGSEL, rnd);
        rchk("chgsel", ADDR_CHGSEL, {2'b00, rnd[5:0]});
        rnd = 8'h01 << ($urandom % 8);
        wr(ADDR_CHGSEL, 8'h00); wr(ADDR_PIEN, rnd); wr(ADDR_INTCTL, 8'h60);
        periph_events <= rnd;
        pulse(0);
        periph_events <= 8'h00;
        wait_for(0, seen); chk("take gie off", 8'h00, {7'h0, seen});
        rchk("piflg", ADDR_PIFLG, rnd);
        rchk("t0 flag", ADDR_INTCTL, 8'h64);
        wr(ADDR_INTCTL, 8'h80);
        wait_for(0, seen); chk("take peripheral_group_enable off", 8'h00, {7'h0, seen});
        wr(ADDR_INTCTL, 8'hC0);
        wait_for(0, seen); chk("periph take", 8'h01, {7'h0, seen});
        wr(ADDR_PIFLG, 8'h00); wr(ADDR_INTCTL, 8'hA0);
        pulse(0);
        wait_for(0, seen); chk("t0 take", 8'h01, {7'h0, seen});
        rchk("gie clear", ADDR_INTCTL, 8'h24);
        wr(ADDR_INTCTL, 8'h20);
        cyc(20);
        rchk("gie back", ADDR_INTCTL, 8'hA0);
        $display("test interrupt take done");
        wr(ADDR_ANALOG_PIN_SELECT, 8'h00);
        for (int e = 0; e < 2; e++) begin
            monitored_port[EXT_PIN] <= e[0]; wr(ADDR_OPTION, {1'b1, e[0], 6'h3F}); wr(ADDR_INTCTL, 8'h00);
            monitored_port[EXT_PIN] <= !e[0]; cyc(6);
            rchk("wrong edge", ADDR_INTCTL, 8'h00);
            monitored_port[EXT_PIN] <= e[0]; cyc(6);
            rchk("valid edge", ADDR_INTCTL, 8'h02);
        end
        wr(ADDR_CHGSEL, 8'h01); wr(ADDR_INTCTL, 8'h00);
        port_access <= 1'b1; monitored_port[0] <= 1'b1; cyc(3); port_access <= 1'b0; cyc(4);
        rchk("lost change", ADDR_INTCTL, 8'h00);
        monitored_port[0] <= 1'b0; cyc(4);
        rchk("change", ADDR_INTCTL, 8'h01);
        wr(ADDR_ANALOG_PIN_SELECT, 8'h04); wr(ADDR_INTCTL, 8'h00); monitored_port[EXT_PIN] <= 1'b0; cyc(6);
        rchk("analog pin", ADDR_INTCTL, 8'h00);
        chk("analog read", 8'h00, {7'h0, port_digital[EXT_PIN]});
        $display("test pin events done");
        wr(ADDR_INTCTL, 8'h20);
        pulse(1);
        chk("asleep", 8'h01, {7'h0, asleep});
        timer0_count <= T0_MAX; cyc(1); timer0_count <= 8'h00;
        wait_for(1, seen); chk("wake", 8'h01, {7'h0, seen});
        rchk("wake status", ADDR_STATUS, 8'h10);
        pulse(2);
        rchk("bor pwr", ADDR_PWR, {6'h00, RST_PWR[1], 1'b0});
        rchk("bor status", ADDR_STATUS, 8'h18);
        pulse(3);
        rchk("master_clear status", ADDR_STATUS, 8'h18);
        rchk("master_clear pwr", ADDR_PWR, {6'h00, RST_PWR[1], 1'b0});
        pulse(1); pulse(3);
        rchk("sleep master_clear", ADDR_STATUS, 8'h10);
        $display("test sleep and resets done");
        wrap_up();
    end
endmodule : mirq_ctrl_tb
bind mirq_ctrl mirq_ctrl_asserts u_chk (.sys_clk(sys_clk), .srst(srst), .rst_kind(rst_kind),
    .irq_pending(irq_pending), .irq_take(irq_take), .pc_cmd(pc_cmd), .q_phase(q_phase), .asleep(asleep));
`default_nettype wire
